// File: design/ubw_pkg.sv
`default_nettype none
package ubw_pkg;
  // ----------------------------------------------------------------
  // register map, byte addresses on the 32-bit AXI4-Lite bus
  // ----------------------------------------------------------------
  localparam int         AXI_AW      = 5;
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_DIV     = 5'h04;
  localparam logic [4:0] OFS_RXDATA  = 5'h08;
  localparam logic [4:0] OFS_ISTAT   = 5'h0C;
  localparam logic [4:0] OFS_IMASK   = 5'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // control register fields (baud_control_reg)
  // ----------------------------------------------------------------
  localparam int CB_ABD_EN  = 0;  // autobaud_enable
  localparam int CB_WAKE_EN = 1;  // wake_on_break_enable
  localparam int CB_ABD_OVF = 2;  // autobaud_overflow_flag
  localparam int CB_HI_SPD  = 3;  // high_speed_baud_select
  localparam int CB_WIDE    = 4;  // wide_baud_generator_select
  localparam int CB_SYNC    = 5;  // synchronous mode select
  localparam int CB_SLEEP   = 6;  // sleep, port clocks stopped
  localparam int CB_RX_IDLE = 7;  // receiver_idle_flag, read only
  localparam int CB_RX_INT  = 8;  // receive_int_flag, read only

  // ----------------------------------------------------------------
  // interrupt status / mask fields and reset values
  // ----------------------------------------------------------------
  localparam int          INT_W       = 3;
  localparam int          IB_ABD_DONE = 0;
  localparam int          IB_WAKE     = 1;
  localparam int          IB_ABD_OVF  = 2;
  localparam logic [15:0] DIV_RST     = 16'h0000;
  localparam logic [2:0]  IMASK_RST   = 3'h0;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int ABD_BITS       = 8;   // bit times between first and last edge
  localparam int ABD_OVS        = 16;  // clocks per divisor step per bit
  localparam int ABD_STEP       = ABD_BITS * ABD_OVS;
  localparam int ABD_EDGES      = 5;
  localparam int BRG_SH_LOW     = 6;   // x64
  localparam int BRG_SH_MID     = 4;   // x16
  localparam int BRG_SH_HIGH    = 2;   // x4
  localparam int FRAME_BITS     = 9;   // start bit plus eight data bits
  localparam int BREAK_BITS_DEF = 13;
  localparam int BREAK_BITS_MIN = 10;
  localparam int IDLE_BITS_DEF  = 2;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DS_IDLE     = 4'b0001,
    DS_ABD_WAIT = 4'b0010,
    DS_ABD_MEAS = 4'b0100,
    DS_WAKE_LOW = 4'b1000
  } ubw_dstate_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_SHIFT = 3'b010,
    HS_GAP   = 3'b100
  } ubw_hstate_t;
endpackage
`default_nettype wire

// File: design/ubw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// receive line from the remote sender to the port
interface ubw_link_if;
  logic serial_in_line;
  modport device (input serial_in_line);
  modport host (output serial_in_line);
endinterface
`default_nettype wire

// File: design/ubw_dev_end.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ubw_dev_end
  import ubw_pkg::*;
#(
  parameter int ABD_STEP_CYC = ABD_STEP
) (
  input  wire logic              CLOCK_IN,        // system clock, 40 MHz
  input  wire logic              RST_N_IN,        // synchronous reset, active low
  ubw_link_if.device             LINK,            // receive line
  input  wire logic [AXI_AW-1:0] AXI_AWADDR_IN,   // write address
  input  wire logic              AXI_AWVALID_IN,  // write address valid
  output logic                   AXI_AWREADY_OUT, // write address ready
  input  wire logic [31:0]       AXI_WDATA_IN,    // write data
  input  wire logic [3:0]        AXI_WSTRB_IN,    // byte strobes
  input  wire logic              AXI_WVALID_IN,   // write data valid
  output logic                   AXI_WREADY_OUT,  // write data ready
  output logic [1:0]             AXI_BRESP_OUT,   // write response
  output logic                   AXI_BVALID_OUT,  // write response valid
  input  wire logic              AXI_BREADY_IN,   // write response ready
  input  wire logic [AXI_AW-1:0] AXI_ARADDR_IN,   // read address
  input  wire logic              AXI_ARVALID_IN,  // read address valid
  output logic                   AXI_ARREADY_OUT, // read address ready
  output logic [31:0]            AXI_RDATA_OUT,   // read data
  output logic [1:0]             AXI_RRESP_OUT,   // read response
  output logic                   AXI_RVALID_OUT,  // read data valid
  input  wire logic              AXI_RREADY_IN,   // read data ready
  output logic                   IRQ_OUT,         // level interrupt
  output logic                   WAKE_OUT,        // one-cycle wake pulse
  output logic                   BAUD_TICK_OUT    // one-cycle baud tick
);
  if (ABD_STEP_CYC < 2 || ABD_STEP_CYC > 128) begin : g_chk
    $error("ABD_STEP_CYC out of range");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return (a[4:2] <= OFS_IMASK[4:2]);
  endfunction

  // clocks per baud tick: factor times (divisor + 1)
  function automatic logic [21:0] baud_period(input logic hs, input logic wide,
                                              input logic [15:0] d);
    logic [21:0] base;
    base = wide ? {6'h00, d} : {14'h0000, d[7:0]};
    base = base + 22'h000001;
    case ({hs, wide})
      2'b00:   return base << BRG_SH_LOW;
      2'b11:   return base << BRG_SH_HIGH;
      default: return base << BRG_SH_MID;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ubw_dstate_t       state_r, state_nxt;
  logic              rx_prev_r, rx_rise, rx_fall;
  logic              abd_en_r, wake_en_r, ovf_r, hs_r, wide_r, sync_r, sleep_r, receive_int_flag_r;
  logic [15:0]       div_r, cnt_r;
  logic [6:0]        presc_r;
  logic [2:0]        edges_r;
  logic [INT_W-1:0]  istat_r, imask_r;
  logic [21:0]       brg_cnt_r;
  logic              wake_evt, wake_end, meas_tick, ovf_evt, abd_done, in_meas;
  logic              aw_hold_r, w_hold_r, do_write, ar_take, rx_read;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0]       wdata_r, ctrl_view, wr_word, w1c_word;
  logic [3:0]        wstrb_r;
  logic              ctrl_wr;

  // ----------------------------------------------------------------
  // line edge detection and events
  // ----------------------------------------------------------------
  // line is taken as synchronous; one flop gives the edges
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= LINK.serial_in_line;
    end
  end

  assign rx_rise   = LINK.serial_in_line & ~rx_prev_r;
  assign rx_fall   = ~LINK.serial_in_line & rx_prev_r;
  assign in_meas   = (state_r == DS_ABD_MEAS);
  // wake is watched in sleep too; sampled here on the system clock
  assign wake_evt  = (state_r == DS_IDLE) & wake_en_r & ~sync_r & rx_fall;
  assign wake_end  = (state_r == DS_WAKE_LOW) & rx_rise;
  assign meas_tick = in_meas & ~sleep_r & (presc_r == 7'(ABD_STEP_CYC - 1));
  assign ovf_evt   = meas_tick & (cnt_r == 16'hFFFF);
  assign abd_done  = in_meas & ~sleep_r & rx_rise & (edges_r == 3'(ABD_EDGES - 1));

  // ----------------------------------------------------------------
  // receive control state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DS_IDLE: begin
        if (wake_evt) begin
          state_nxt = DS_WAKE_LOW;
        end else if (abd_en_r & ~wake_en_r & ~sleep_r) begin
          state_nxt = DS_ABD_WAIT;
        end
      end
      DS_ABD_WAIT: begin
        if (!abd_en_r || wake_en_r) begin
          state_nxt = DS_IDLE;
        end else if (rx_rise && !sleep_r) begin
          state_nxt = DS_ABD_MEAS;
        end
      end
      DS_ABD_MEAS: begin
        if (!abd_en_r || wake_en_r || abd_done) begin
          state_nxt = DS_IDLE;
        end
      end
      DS_WAKE_LOW: begin
        if (wake_end || !wake_en_r) begin
          state_nxt = DS_IDLE;
        end
      end
      default: state_nxt = DS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      state_r <= DS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // auto-baud measurement counter
  // ----------------------------------------------------------------
  // counting wraps on overflow so the fifth edge still ends the run
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN || state_r != DS_ABD_MEAS) begin
      presc_r <= 7'h00;
      cnt_r   <= 16'h0000;
      edges_r <= 3'h1;
    end else if (!sleep_r) begin
      presc_r <= meas_tick ? 7'h00 : presc_r + 7'h01;
      if (meas_tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      if (rx_rise) begin
        edges_r <= edges_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // held cleared in sleep and while waiting for a wake event
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN || sleep_r || wake_en_r) begin
      brg_cnt_r     <= 22'h000000;
      BAUD_TICK_OUT <= 1'b0;
    end else if (brg_cnt_r >= baud_period(hs_r, wide_r, div_r) - 22'h000001) begin
      brg_cnt_r     <= 22'h000000;
      BAUD_TICK_OUT <= 1'b1;
    end else begin
      brg_cnt_r     <= brg_cnt_r + 22'h000001;
      BAUD_TICK_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign do_write  = aw_hold_r & w_hold_r & ~AXI_BVALID_OUT;
  assign ctrl_view = {23'h000000, receive_int_flag_r, ~in_meas, sleep_r, sync_r, wide_r, hs_r,
                      ovf_r, wake_en_r, abd_en_r};
  assign wr_word   = merge((awaddr_r[4:2] == OFS_DIV[4:2]) ? {16'h0000, div_r} :
                           (awaddr_r[4:2] == OFS_CTRL[4:2]) ? ctrl_view :
                           (awaddr_r[4:2] == OFS_IMASK[4:2]) ? {29'h0, imask_r} : 32'h0,
                           wdata_r, wstrb_r);
  assign ctrl_wr   = do_write & (awaddr_r[4:2] == OFS_CTRL[4:2]);
  // strobed ones of a status write, each one clears its bit
  assign w1c_word  = merge(32'h0, wdata_r, wstrb_r);

  // address and data are held separately, taken in either order
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      aw_hold_r       <= 1'b0;
      w_hold_r        <= 1'b0;
      awaddr_r        <= '0;
      wdata_r         <= 32'h0;
      wstrb_r         <= 4'h0;
      AXI_AWREADY_OUT <= 1'b1;
      AXI_WREADY_OUT  <= 1'b1;
      AXI_BVALID_OUT  <= 1'b0;
      AXI_BRESP_OUT   <= RESP_OKAY;
    end else begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_hold_r       <= 1'b1;
        awaddr_r        <= AXI_AWADDR_IN;
        AXI_AWREADY_OUT <= 1'b0;
      end else if (do_write) begin
        aw_hold_r       <= 1'b0;
        AXI_AWREADY_OUT <= 1'b1;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_hold_r       <= 1'b1;
        wdata_r        <= AXI_WDATA_IN;
        wstrb_r        <= AXI_WSTRB_IN;
        AXI_WREADY_OUT <= 1'b0;
      end else if (do_write) begin
        w_hold_r       <= 1'b0;
        AXI_WREADY_OUT <= 1'b1;
      end
      if (do_write) begin
        AXI_BVALID_OUT <= 1'b1;
        AXI_BRESP_OUT  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (AXI_BREADY_IN) begin
        AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign ar_take = AXI_ARVALID_IN & AXI_ARREADY_OUT;
  assign rx_read = ar_take & (AXI_ARADDR_IN[4:2] == OFS_RXDATA[4:2]);

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      AXI_ARREADY_OUT <= 1'b1;
      AXI_RVALID_OUT  <= 1'b0;
      AXI_RDATA_OUT   <= 32'h0;
      AXI_RRESP_OUT   <= RESP_OKAY;
    end else if (ar_take) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT  <= 1'b1;
      AXI_RRESP_OUT   <= mapped(AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
      case (AXI_ARADDR_IN[4:2])
        OFS_CTRL[4:2]:  AXI_RDATA_OUT <= ctrl_view;
        OFS_DIV[4:2]:   AXI_RDATA_OUT <= {16'h0000, div_r};
        OFS_ISTAT[4:2]: AXI_RDATA_OUT <= {29'h0, istat_r};
        OFS_IMASK[4:2]: AXI_RDATA_OUT <= {29'h0, imask_r};
        default:        AXI_RDATA_OUT <= 32'h0; // no receive datapath here
      endcase
    end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
      AXI_ARREADY_OUT <= 1'b1;
      AXI_RVALID_OUT  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  // a software write wins over the hardware clear of an enable
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      {abd_en_r, wake_en_r, hs_r, wide_r, sync_r, sleep_r} <= 6'h00;
    end else if (ctrl_wr) begin
      abd_en_r  <= wr_word[CB_ABD_EN];
      wake_en_r <= wr_word[CB_WAKE_EN];
      hs_r      <= wr_word[CB_HI_SPD];
      wide_r    <= wr_word[CB_WIDE];
      sync_r    <= wr_word[CB_SYNC];
      sleep_r   <= wr_word[CB_SLEEP];
    end else begin
      if (abd_done) begin
        abd_en_r <= 1'b0;
      end
      if (wake_end) begin
        wake_en_r <= 1'b0;
      end
    end
  end

  // overflow: set wins; clear only once enable is already low
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ovf_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_r <= 1'b1;
    end else if (ctrl_wr && !wr_word[CB_ABD_OVF] && !abd_en_r) begin
      ovf_r <= 1'b0;
    end
  end

  // receive flag: set by auto-baud end or wake, cleared by data read
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      receive_int_flag_r <= 1'b0;
    end else if (abd_done || wake_evt) begin
      receive_int_flag_r <= 1'b1;
    end else if (rx_read) begin
      receive_int_flag_r <= 1'b0;
    end
  end

  // measured divisor is the step count less one
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      div_r <= DIV_RST;
    end else if (abd_done) begin
      div_r <= (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
    end else if (do_write && awaddr_r[4:2] == OFS_DIV[4:2]) begin
      div_r <= wr_word[15:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      istat_r  <= '0;
      imask_r  <= IMASK_RST;
      IRQ_OUT  <= 1'b0;
      WAKE_OUT <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~((do_write && awaddr_r[4:2] == OFS_ISTAT[4:2]) ?
                              w1c_word[INT_W-1:0] : 3'h0)) | {ovf_evt, wake_evt, abd_done};
      if (do_write && awaddr_r[4:2] == OFS_IMASK[4:2]) begin
        imask_r <= wr_word[INT_W-1:0];
      end
      IRQ_OUT  <= |(istat_r & imask_r);
      WAKE_OUT <= wake_evt;
    end
  end
endmodule
`default_nettype wire

// File: design/ubw_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module ubw_host_end
  import ubw_pkg::*;
#(
  parameter int BREAK_BITS = BREAK_BITS_DEF,
  parameter int IDLE_BITS  = IDLE_BITS_DEF
) (
  input  wire logic        CLOCK_IN,     // system clock
  input  wire logic        RST_N_IN,     // synchronous reset, active low
  ubw_link_if.host         LINK,         // driven receive line
  input  wire logic [15:0] BIT_CYCLES_IN, // clocks per bit, latched at start
  input  wire logic        SEND_IN,      // pulse: send DATA_IN as a frame
  input  wire logic [7:0]  DATA_IN,      // byte to send
  input  wire logic        BREAK_IN,     // pulse: send an all-zero break
  output logic             BUSY_OUT,     // frame or gap in progress
  output logic             DONE_OUT      // one-cycle pulse after the gap
);
  if (BREAK_BITS < BREAK_BITS_MIN || BREAK_BITS > 200 || IDLE_BITS < 1 || IDLE_BITS > 50)
  begin : g_chk
    $error("break or idle length out of range");
  end

  // ----------------------------------------------------------------
  // sender state
  // ----------------------------------------------------------------
  ubw_hstate_t state_r;
  logic        line_r;
  logic [8:0]  shift_r;
  logic [7:0]  bits_r;
  logic [15:0] cyc_r, bitcnt_r;
  logic        bit_end;

  assign LINK.serial_in_line = line_r;
  assign bit_end             = (bitcnt_r == cyc_r - 16'h0001);

  // start bit plus data LSB first, or a long zero run, then idle high
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      state_r  <= HS_IDLE;
      line_r   <= 1'b1;
      shift_r  <= 9'h000;
      bits_r   <= 8'h00;
      cyc_r    <= 16'h0001;
      bitcnt_r <= 16'h0000;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
    end else begin
      DONE_OUT <= 1'b0;
      case (state_r)
        HS_IDLE: begin
          if (BREAK_IN || SEND_IN) begin
            state_r  <= HS_SHIFT;
            line_r   <= 1'b0;
            // break is all zeros so no fragment follows the wake
            shift_r  <= BREAK_IN ? 9'h000 : {DATA_IN, 1'b0};
            bits_r   <= BREAK_IN ? 8'(BREAK_BITS) : 8'(FRAME_BITS);
            cyc_r    <= (BIT_CYCLES_IN == 16'h0000) ? 16'h0001 : BIT_CYCLES_IN;
            bitcnt_r <= 16'h0000;
            BUSY_OUT <= 1'b1;
          end
        end
        HS_SHIFT: begin
          bitcnt_r <= bit_end ? 16'h0000 : bitcnt_r + 16'h0001;
          if (bit_end) begin
            if (bits_r == 8'h01) begin
              // stop bit and idle give the far end time to start up
              state_r <= HS_GAP;
              line_r  <= 1'b1;
              bits_r  <= 8'(IDLE_BITS + 1);
            end else begin
              bits_r  <= bits_r - 8'h01;
              line_r  <= shift_r[1];
              shift_r <= shift_r >> 1;
            end
          end
        end
        HS_GAP: begin
          bitcnt_r <= bit_end ? 16'h0000 : bitcnt_r + 16'h0001;
          if (bit_end) begin
            if (bits_r == 8'h01) begin
              state_r  <= HS_IDLE;
              BUSY_OUT <= 1'b0;
              DONE_OUT <= 1'b1;
            end else begin
              bits_r <= bits_r - 8'h01;
            end
          end
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: dv/ubw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// link and status watcher
// ----------------------------------------------------------------
module ubw_monitor (
  input wire logic CLOCK_IN,        // system clock
  input wire logic RST_N_IN,        // reset, active low
  input wire logic serial_in_line,  // link line
  input wire logic WAKE_OUT,        // wake pulse
  input wire logic BAUD_TICK_OUT,   // baud tick
  input wire logic AXI_ARVALID_IN,  // read request
  input wire logic AXI_ARREADY_OUT, // read ready
  input wire logic AXI_RVALID_OUT,  // read answer
  input wire logic AXI_BVALID_OUT,  // write answer
  input wire logic AXI_BREADY_IN,   // write answer taken
  input wire logic AXI_AWREADY_OUT  // write address ready
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // shortest baud period is four clocks, so a tick is never followed closely
  sequence s_quiet3;
    !BAUD_TICK_OUT [*3];
  endsequence
  property p_wake_low; WAKE_OUT |-> !serial_in_line; endproperty
  property p_wake_once; WAKE_OUT |=> !WAKE_OUT; endproperty
  property p_wake_quiet; WAKE_OUT |-> s_quiet3; endproperty
  property p_tick_gap; BAUD_TICK_OUT |=> s_quiet3; endproperty
  property p_rd_lat; AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT; endproperty
  property p_rd_refuse; AXI_RVALID_OUT |-> !AXI_ARREADY_OUT; endproperty
  property p_b_hold; AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT; endproperty
  // the address slot is freed when the answer is offered; a new write then waits
  property p_aw_busy; $rose(AXI_BVALID_OUT) |-> AXI_AWREADY_OUT; endproperty
  a_wake_low: assert property (p_wake_low) else $error("wake with line high");
  a_wake_once: assert property (p_wake_once) else $error("wake pulse too long");
  a_wake_quiet: assert property (p_wake_quiet) else $error("tick during wake");
  a_tick_gap: assert property (p_tick_gap) else $error("baud ticks too close");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_rd_refuse: assert property (p_rd_refuse) else $error("read taken while busy");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_aw_busy: assert property (p_aw_busy) else $error("write address not freed");
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ubw_pkg::*;
  localparam int STEP = 4;  // shortened measurement step
  localparam int NB   = 20; // clocks per bit on the link
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, send = 0, brk = 0;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got;
  logic        awready, wready, bvalid, arready, rvalid, irq, wake, tick, busy, done;
  logic [1:0]  bresp, rresp, rr;
  logic [7:0]  tx = 0;
  int          n_errors = 0, total_checks = 0, n_wake = 0, i, t, div;
  logic [31:0] wmode [4] = '{32'h02, 32'h42, 32'h22, 32'h02}; // plain, asleep, sync, char
  ubw_link_if link ();
  always #12.5 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) n_wake <= n_wake + 1;
  ubw_dev_end #(.ABD_STEP_CYC(STEP)) ubw_dev_end_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .LINK(link.device), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF),
    .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
    .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
    .IRQ_OUT(irq), .WAKE_OUT(wake), .BAUD_TICK_OUT(tick));
  ubw_host_end ubw_host_end_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n), .LINK(link.host),
    .BIT_CYCLES_IN(16'(NB)), .SEND_IN(send), .DATA_IN(tx), .BREAK_IN(brk),
    .BUSY_OUT(busy), .DONE_OUT(done));
  ubw_monitor ubw_monitor_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .serial_in_line(link.serial_in_line), .WAKE_OUT(wake), .BAUD_TICK_OUT(tick),
    .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RVALID_OUT(rvalid),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_AWREADY_OUT(awready));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit ta, tw;
    {ta, tw} = 2'b00;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    while (!(ta && tw)) begin
      @(posedge clk);
      if (awready === 1'b1) ta = 1'b1;
      if (wready === 1'b1) tw = 1'b1;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    while (bvalid !== 1'b1) @(posedge clk);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // one frame or break from the far end, waits for its gap to pass
  task automatic xfer(input logic b, input logic [7:0] v);
    @(posedge clk);
    {brk, send, tx} <= {b, !b, v};
    @(posedge clk);
    {brk, send} <= 2'b00;
    @(posedge clk);
    chk(32'(busy), 32'h1);
    while (done !== 1'b1) @(posedge clk);
  endtask
  // the first period after a change may be partial, so skip it
  task automatic period(output int p);
    p = 0;
    repeat (2) do @(posedge clk); while (tick !== 1'b1);
    do begin @(posedge clk); p++; end while (tick !== 1'b1);
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #2000000;
    n_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(88427));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, got);
    chk(got, 32'h80);
    rd(5'h14, got);
    chk({got[29:0], rr}, {30'h0, RESP_SLVERR});
    wr(5'h14, 32'h0);
    chk(32'(rr), 32'(RESP_SLVERR));
    // measurement over a 0x55 frame: eight bit times between first and fifth rise
    wr(OFS_CTRL, 32'h1 << CB_ABD_EN);
    chk(32'(rr), 32'(RESP_OKAY));
    xfer(1'b0, 8'h55);
    div = 8 * NB / STEP - 1;
    rd(OFS_DIV, got);
    chk(32'(got + 1 >= div && got <= div + 1), 32'h1);
    rd(OFS_CTRL, got);
    chk(got & 32'h101, 32'h100);
    rd(OFS_ISTAT, got);
    chk(got & 32'h1, 32'h1);
    chk(32'(irq), 32'h0);
    rd(OFS_RXDATA, got);
    rd(OFS_CTRL, got);
    chk(got & 32'h100, 32'h0);
    // abort order: enable off first, then the flag
    wr(OFS_CTRL, 32'h1 << CB_ABD_EN);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_CTRL, got);
    chk(got, 32'h80);
    wr(OFS_ISTAT, 32'h7);
    wr(OFS_IMASK, 32'h1 << IB_WAKE);
    for (i = 0; i < 4; i++) begin
      t = n_wake;
      wr(OFS_CTRL, wmode[i]);
      xfer(i != 3, 8'($urandom) | 8'h01);
      chk(32'(n_wake - t), 32'(i != 2));
      if (i != 2) begin
        chk(32'(irq), 32'h1);
        rd(OFS_CTRL, got);
        chk(got & 32'h102, 32'h100);
      end
      rd(OFS_RXDATA, got);
      wr(OFS_ISTAT, 32'h7);
      wr(OFS_CTRL, 32'h0);
      chk(32'(irq), 32'h0);
      rd(OFS_CTRL, got);
      chk(got & 32'h100, 32'h0);
    end
    // baud period in all four speed selections, narrow divisor uses low byte
    for (i = 0; i < 4; i++) begin
      div = 32'h100 | ($urandom % 8);
      wr(OFS_DIV, 32'(div));
      wr(OFS_CTRL, 32'(i) << CB_HI_SPD);
      period(t);
      chk(32'(t), 32'(((i[1] ? div : div & 8'hFF) + 1) << (i == 0 ? 6 : i == 3 ? 2 : 4)));
    end
    end_of_test;
  end
endmodule
`default_nettype wire
